/* cacx_pkg.sv */
package cacx_pkg;
  // Register map of the configuration slave
  localparam int ADDR_W = 12;
  localparam logic [11:0] CTRL_OFS = 12'h100;
  localparam logic [11:0] AUX_OFS = 12'h104;
  localparam logic [11:0] INT_MASK_OFS = 12'h214;
  localparam logic [11:0] INT_CLEAR_OFS = 12'h220;
  // Write responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // Main control fields
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RST = 1'h0;
  // Auxiliary configuration fields
  localparam int AUX_EARLY_RESP = 30;
  localparam int AUX_IPF_EN = 29;
  localparam int AUX_DPF_EN = 28;
  localparam int AUX_NS_INT = 27;
  localparam int AUX_NS_LOCK = 26;
  localparam int AUX_REPL_RR = 25;
  localparam int AUX_WALLOC_HI = 24;
  localparam int AUX_WALLOC_LO = 23;
  localparam int AUX_SHARED_OVR = 22;
  localparam int AUX_PARITY = 21;
  localparam int AUX_EVBUS = 20;
  localparam int AUX_WAY_HI = 19;
  localparam int AUX_WAY_LO = 17;
  localparam int AUX_ASSOC = 16;
  localparam int AUX_SHARED_INV = 13;
  localparam int AUX_EXCL = 12;
  localparam int AUX_SB_LIMIT = 11;
  localparam int AUX_HIPRI_RD = 10;
  localparam int AUX_ZERO_LINE = 0;
  // Writable bits; reserved 31, 15:14 and 9:1 stay zero
  localparam logic [31:0] AUX_WMASK = 32'h7FFF3C01;
  // Fixed part of the reset value: round-robin replacement
  localparam logic [31:0] AUX_RST = 32'h02000000;
  // Build-time support for the 16-way arrangement
  localparam logic ASSOC_16_BUILT = 1'h1;
  // Write-allocate modes
  localparam logic [1:0] WALLOC_ATTR = 2'h0;
  localparam logic [1:0] WALLOC_NONE = 2'h1;
  localparam logic [1:0] WALLOC_FORCE = 2'h2;
  localparam logic [1:0] WALLOC_ALIAS = 2'h3;
  // Way-size codes at the ends of the range
  localparam logic [2:0] WAY_RSV_LO = 3'h0;
  localparam logic [2:0] WAY_16K = 3'h1;
  localparam logic [2:0] WAY_512K = 3'h6;
  localparam logic [2:0] WAY_RSV_HI = 3'h7;
endpackage

/* cacx_aux_config.sv */
// Operation
// - Non-secure write to aux register: no update, decode error response
// - Aux register readable by secure and non-secure accesses alike
// - Write to aux register while cache enabled gets slave error
// - Non-secure write while enabled reports decode error, not slave error
// - Reserved bits 31, 15:14, 9:1 read zero; writers preserve them
// - Bit 30 enables early write response, reset 0
// - Bit 29 enables instruction prefetch, reset 0
// - Bit 28 enables data prefetch, reset 0
// - Bit 27 lets non-secure accesses reach interrupt mask and clear
// - Bit 26 lets non-secure writes modify lockdown registers
// - Bit 25 picks round-robin (1, reset) or pseudo-random replacement
// - Bits 24:23 write-allocate mode; 11 behaves as 00
// - Bit 22 makes shared attribute ignored, reset 0
// - Bits 21, 20, 12 enable parity, event bus, exclusive mode
// - Bits 19:17 way size clamped to 16KB..512KB; bit 16 associativity
// - Way-size reset value comes from strap inputs
// - Bit 13 shared invalidate, effective only with override clear
// - Bit 11 keeps one store buffer slot free of device writes
// - Bit 10 gives strongly ordered and device reads top priority
// - Bit 0 enables full-line zero writes, reset 0
// - Associativity reset value follows strap and build configuration
// - Cache enable is bit 0 of main control register
`timescale 1ns/100ps
`default_nettype none
module cacx_aux_config (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic secure,
  output logic [31:0] rdata,
  output logic resp_valid,
  output logic [1:0] resp,
  input wire logic [2:0] way_capacity_straps,
  input wire logic assoc_strap,
  output logic cache_enable,
  output logic early_resp_en,
  output logic inst_prefetch_en,
  output logic data_prefetch_en,
  output logic int_access_ok,
  output logic lockdown_write_ok,
  output logic repl_round_robin,
  output logic [1:0] write_allocate_hint,
  output logic shared_override,
  output logic parity_en,
  output logic event_bus_en,
  output logic [2:0] way_size,
  output logic assoc_16way,
  output logic shared_inval_en,
  output logic exclusive_en,
  output logic sb_device_limit,
  output logic hipri_dev_reads,
  output logic zero_line_en
);

  ////////////////////////////////////////////////////////////////////////////
  // Strap synchronisers, free running so reset sees settled values

  logic [2:0] way_s1_r;
  logic [2:0] way_s2_r;
  logic assoc_s1_r;
  logic assoc_s2_r;
  logic [2:0] way_s1_nxt;
  logic [2:0] way_s2_nxt;
  logic assoc_s1_nxt;
  logic assoc_s2_nxt;

  always_comb begin
    way_s1_nxt = way_capacity_straps;
    way_s2_nxt = way_s1_r;
    assoc_s1_nxt = assoc_strap;
    assoc_s2_nxt = assoc_s1_r;
  end

  always_ff @(posedge sys_clk) begin
    way_s1_r <= way_s1_nxt;
    way_s2_r <= way_s2_nxt;
    assoc_s1_r <= assoc_s1_nxt;
    assoc_s2_r <= assoc_s2_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bus decode and update

  logic [31:0] aux_r;
  logic [31:0] aux_nxt;
  logic [31:0] aux_rst_val;
  logic en_r;
  logic en_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic resp_valid_r;
  logic resp_valid_nxt;
  logic [1:0] resp_r;
  logic [1:0] resp_nxt;
  logic aux_sel;
  logic ctl_sel;

  always_comb begin
    aux_sel = (addr == cacx_pkg::AUX_OFS);
    ctl_sel = (addr == cacx_pkg::CTRL_OFS);
    aux_rst_val = cacx_pkg::AUX_RST;
    aux_rst_val[cacx_pkg::AUX_WAY_HI:cacx_pkg::AUX_WAY_LO] = way_s2_r;
    aux_rst_val[cacx_pkg::AUX_ASSOC] = assoc_s2_r & cacx_pkg::ASSOC_16_BUILT;
    aux_nxt = aux_r;
    en_nxt = en_r;
    resp_valid_nxt = wr;
    resp_nxt = cacx_pkg::RESP_OKAY;
    rdata_nxt = 32'h00000000;
    if (wr) begin
      if (!(aux_sel || ctl_sel)) begin
        resp_nxt = cacx_pkg::RESP_DECERR;
      end else if (!secure) begin
        // Security check ranks above the enable check
        resp_nxt = cacx_pkg::RESP_DECERR;
      end else if (aux_sel && en_r) begin
        resp_nxt = cacx_pkg::RESP_SLVERR;
      end else if (aux_sel) begin
        aux_nxt = wdata & cacx_pkg::AUX_WMASK;
      end else begin
        en_nxt = wdata[cacx_pkg::CTRL_EN_BIT];
      end
    end
    if (rd) begin
      if (aux_sel) begin
        rdata_nxt = aux_r;
      end else if (ctl_sel) begin
        rdata_nxt = {31'h00000000, en_r};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      aux_r <= aux_rst_val;
      en_r <= cacx_pkg::CTRL_EN_RST;
      rdata_r <= 32'h00000000;
      resp_valid_r <= 1'h0;
      resp_r <= cacx_pkg::RESP_OKAY;
    end else begin
      aux_r <= aux_nxt;
      en_r <= en_nxt;
      rdata_r <= rdata_nxt;
      resp_valid_r <= resp_valid_nxt;
      resp_r <= resp_nxt;
    end
  end

  assign rdata = rdata_r;
  assign resp_valid = resp_valid_r;
  assign resp = resp_r;
  assign cache_enable = en_r;

  ////////////////////////////////////////////////////////////////////////////
  // Option fields toward the cache datapath

  logic [31:0] opt_src;
  logic [1:0] walloc_raw;
  logic [2:0] way_raw;
  logic [1:0] walloc_r;
  logic [1:0] walloc_nxt;
  logic [2:0] way_size_r;
  logic [2:0] way_size_nxt;
  logic shared_inval_r;
  logic shared_inval_nxt;

  always_comb begin
    // Decoded from the register's own next value, so the views never lag it
    opt_src = rst ? aux_rst_val : aux_nxt;
    walloc_raw = opt_src[cacx_pkg::AUX_WALLOC_HI:cacx_pkg::AUX_WALLOC_LO];
    way_raw = opt_src[cacx_pkg::AUX_WAY_HI:cacx_pkg::AUX_WAY_LO];
    // Alias folded here so the datapath sees only three modes
    walloc_nxt = (walloc_raw == cacx_pkg::WALLOC_ALIAS) ? cacx_pkg::WALLOC_ATTR
      : walloc_raw;
    if (way_raw == cacx_pkg::WAY_RSV_LO) begin
      way_size_nxt = cacx_pkg::WAY_16K;
    end else if (way_raw == cacx_pkg::WAY_RSV_HI) begin
      way_size_nxt = cacx_pkg::WAY_512K;
    end else begin
      way_size_nxt = way_raw;
    end
    // Override wins: invalidate behaviour needs the shared attribute honoured
    shared_inval_nxt = opt_src[cacx_pkg::AUX_SHARED_INV]
      && !opt_src[cacx_pkg::AUX_SHARED_OVR];
  end

  always_ff @(posedge sys_clk) begin
    walloc_r <= walloc_nxt;
    way_size_r <= way_size_nxt;
    shared_inval_r <= shared_inval_nxt;
  end

  assign write_allocate_hint = walloc_r;
  assign way_size = way_size_r;

  assign early_resp_en = aux_r[cacx_pkg::AUX_EARLY_RESP];
  assign inst_prefetch_en = aux_r[cacx_pkg::AUX_IPF_EN];
  assign data_prefetch_en = aux_r[cacx_pkg::AUX_DPF_EN];
  // Qualifies the current access to either interrupt register
  assign int_access_ok = (rd || wr) && (addr == cacx_pkg::INT_MASK_OFS
    || addr == cacx_pkg::INT_CLEAR_OFS) && (secure || aux_r[cacx_pkg::AUX_NS_INT]);
  assign lockdown_write_ok = secure || aux_r[cacx_pkg::AUX_NS_LOCK];
  assign repl_round_robin = aux_r[cacx_pkg::AUX_REPL_RR];
  assign shared_override = aux_r[cacx_pkg::AUX_SHARED_OVR];
  assign parity_en = aux_r[cacx_pkg::AUX_PARITY];
  assign event_bus_en = aux_r[cacx_pkg::AUX_EVBUS];
  assign exclusive_en = aux_r[cacx_pkg::AUX_EXCL];
  assign assoc_16way = aux_r[cacx_pkg::AUX_ASSOC];
  assign shared_inval_en = shared_inval_r;
  assign sb_device_limit = aux_r[cacx_pkg::AUX_SB_LIMIT];
  assign hipri_dev_reads = aux_r[cacx_pkg::AUX_HIPRI_RD];
  assign zero_line_en = aux_r[cacx_pkg::AUX_ZERO_LINE];

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_ns_write_decerr;
    @(posedge sys_clk) disable iff (rst)
    (wr && aux_sel && !secure) |=> resp_valid && resp == cacx_pkg::RESP_DECERR
      && $stable(aux_r);
  endproperty
  a_ns_write_decerr: assert property (p_ns_write_decerr)
    else $error("non-secure aux write not refused");

  property p_read_any;
    @(posedge sys_clk) disable iff (rst)
    (rd && aux_sel) |=> rdata == $past(aux_r);
  endproperty
  a_read_any: assert property (p_read_any)
    else $error("aux read data wrong");

  property p_enabled_slverr;
    @(posedge sys_clk) disable iff (rst)
    (wr && aux_sel && secure && en_r) |=> resp == cacx_pkg::RESP_SLVERR
      && $stable(aux_r);
  endproperty
  a_enabled_slverr: assert property (p_enabled_slverr)
    else $error("aux write while enabled not refused");

  property p_decerr_first;
    @(posedge sys_clk) disable iff (rst)
    (wr && aux_sel && !secure && en_r) |=> resp == cacx_pkg::RESP_DECERR;
  endproperty
  a_decerr_first: assert property (p_decerr_first)
    else $error("slave error reported over decode error");

  property p_rsvd_zero;
    @(posedge sys_clk) disable iff (rst)
    $past(rd && aux_sel) |-> (rdata & ~cacx_pkg::AUX_WMASK) == 32'h00000000;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved aux bits read non-zero");

  property p_write_ok;
    @(posedge sys_clk) disable iff (rst)
    (wr && aux_sel && secure && !en_r) |=> resp == cacx_pkg::RESP_OKAY
      && aux_r == ($past(wdata) & cacx_pkg::AUX_WMASK);
  endproperty
  a_write_ok: assert property (p_write_ok)
    else $error("accepted aux write not applied");

  property p_strap_reset;
    @(posedge sys_clk)
    $fell(rst) |-> aux_r[cacx_pkg::AUX_WAY_HI:cacx_pkg::AUX_WAY_LO] == $past(way_s2_r)
      && aux_r[cacx_pkg::AUX_REPL_RR] && !aux_r[cacx_pkg::AUX_EARLY_RESP];
  endproperty
  a_strap_reset: assert property (p_strap_reset)
    else $error("aux reset value wrong");

  property p_int_gate;
    @(posedge sys_clk) disable iff (rst)
    (rd && addr == cacx_pkg::INT_MASK_OFS && !secure && !aux_r[cacx_pkg::AUX_NS_INT])
      |-> !int_access_ok;
  endproperty
  a_int_gate: assert property (p_int_gate)
    else $error("non-secure interrupt access allowed");

  property p_shared_inv;
    @(posedge sys_clk) disable iff (rst)
    shared_override |-> !shared_inval_en;
  endproperty
  a_shared_inv: assert property (p_shared_inv)
    else $error("shared invalidate active under override");

  property p_way_clamp;
    @(posedge sys_clk) disable iff (rst)
    way_size != cacx_pkg::WAY_RSV_LO && way_size != cacx_pkg::WAY_RSV_HI;
  endproperty
  a_way_clamp: assert property (p_way_clamp)
    else $error("reserved way size reached datapath");

  property p_resp_pulse;
    @(posedge sys_clk) disable iff (rst)
    resp_valid |-> $past(wr);
  endproperty
  a_resp_pulse: assert property (p_resp_pulse)
    else $error("write response without write");

  property p_early_resp_rst;
    @(posedge sys_clk)
    $fell(rst) |-> !early_resp_en;
  endproperty
  a_early_resp_rst: assert property (p_early_resp_rst)
    else $error("early write response on after reset");

  property p_prefetch_rst;
    @(posedge sys_clk)
    $fell(rst) |-> !inst_prefetch_en && !data_prefetch_en;
  endproperty
  a_prefetch_rst: assert property (p_prefetch_rst)
    else $error("prefetch on after reset");

  property p_lock_gate;
    @(posedge sys_clk) disable iff (rst)
    (!secure && !aux_r[cacx_pkg::AUX_NS_LOCK]) |-> !lockdown_write_ok;
  endproperty
  a_lock_gate: assert property (p_lock_gate)
    else $error("non-secure lockdown write allowed");

  property p_repl_rst;
    @(posedge sys_clk)
    $fell(rst) |-> repl_round_robin;
  endproperty
  a_repl_rst: assert property (p_repl_rst)
    else $error("replacement not round-robin after reset");

  property p_walloc_alias;
    @(posedge sys_clk) disable iff (rst)
    aux_r[cacx_pkg::AUX_WALLOC_HI:cacx_pkg::AUX_WALLOC_LO] == cacx_pkg::WALLOC_ALIAS
      |-> write_allocate_hint == cacx_pkg::WALLOC_ATTR;
  endproperty
  a_walloc_alias: assert property (p_walloc_alias)
    else $error("write-allocate alias not folded");

  property p_shared_ovr_rst;
    @(posedge sys_clk)
    $fell(rst) |-> !shared_override && !shared_inval_en;
  endproperty
  a_shared_ovr_rst: assert property (p_shared_ovr_rst)
    else $error("shared handling not default after reset");

  property p_opt_en_rst;
    @(posedge sys_clk)
    $fell(rst) |-> !parity_en && !event_bus_en && !exclusive_en;
  endproperty
  a_opt_en_rst: assert property (p_opt_en_rst)
    else $error("parity, event bus or exclusive on after reset");

  property p_way_pass;
    @(posedge sys_clk) disable iff (rst)
    (aux_r[cacx_pkg::AUX_WAY_HI:cacx_pkg::AUX_WAY_LO] != cacx_pkg::WAY_RSV_LO
      && aux_r[cacx_pkg::AUX_WAY_HI:cacx_pkg::AUX_WAY_LO] != cacx_pkg::WAY_RSV_HI)
      |-> way_size == aux_r[cacx_pkg::AUX_WAY_HI:cacx_pkg::AUX_WAY_LO];
  endproperty
  a_way_pass: assert property (p_way_pass)
    else $error("legal way size altered");

  property p_shared_inv_on;
    @(posedge sys_clk) disable iff (rst)
    (aux_r[cacx_pkg::AUX_SHARED_INV] && !shared_override) |-> shared_inval_en;
  endproperty
  a_shared_inv_on: assert property (p_shared_inv_on)
    else $error("shared invalidate missing without override");

  property p_dev_opts_rst;
    @(posedge sys_clk)
    $fell(rst) |-> !sb_device_limit && !hipri_dev_reads && !zero_line_en;
  endproperty
  a_dev_opts_rst: assert property (p_dev_opts_rst)
    else $error("device or zero-line option on after reset");

  property p_assoc_reset;
    @(posedge sys_clk)
    $fell(rst) |-> assoc_16way == ($past(assoc_s2_r) & cacx_pkg::ASSOC_16_BUILT);
  endproperty
  a_assoc_reset: assert property (p_assoc_reset)
    else $error("associativity reset value wrong");

  property p_ctrl_write;
    @(posedge sys_clk) disable iff (rst)
    (wr && ctl_sel && secure) |=> cache_enable == $past(wdata[cacx_pkg::CTRL_EN_BIT]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("cache enable not written");

endmodule
`default_nettype wire

/* cacx_master.sv */
`timescale 1ns/100ps
`default_nettype none
module cacx_master (
  input wire logic sys_clk,
  input wire logic [31:0] rdata,
  input wire logic resp_valid,
  input wire logic [1:0] resp,
  input wire logic [1:0] gate,
  output logic [11:0] addr,
  output logic [31:0] wdata,
  output logic wr,
  output logic rd,
  output logic secure
);
  initial begin
    addr = 12'h000;
    wdata = 32'h00000000;
    wr = 1'b0;
    rd = 1'b0;
    secure = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  // One access; the slave never stalls, answer lands one edge later
  task automatic access(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic s, output logic [31:0] q, output logic [1:0] g);
    @(posedge sys_clk);
    addr <= a;
    wdata <= (a == cacx_pkg::AUX_OFS) ? (d & cacx_pkg::AUX_WMASK) : d;
    secure <= s;
    wr <= w;
    rd <= !w;
    #1;
    g = gate;
    @(posedge sys_clk);
    wr <= 1'b0;
    rd <= 1'b0;
    // Released lines carry inverted junk so stale values cannot pass
    addr <= ~a;
    wdata <= ~d;
    secure <= ~s;
    #1;
    q = w ? {29'h0, resp_valid, resp} : rdata;
  endtask
endmodule
`default_nettype wire

/* tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic sys_clk;
  logic rst;
  logic [2:0] straps;
  logic assoc;
  wire logic [11:0] addr;
  wire logic [31:0] wdata;
  wire logic wr;
  wire logic rd;
  wire logic secure;
  wire logic [31:0] rdata;
  wire logic resp_valid;
  wire logic [1:0] resp;
  wire logic [1:0] gate;
  wire logic [18:0] o;
  int fail_count;
  int num_checks;
  logic [31:0] aux;
  logic [31:0] q;
  logic [31:0] d;
  logic s;
  logic en;

  cacx_master i_mst (.sys_clk(sys_clk), .rdata(rdata), .resp_valid(resp_valid),
    .resp(resp), .gate(gate), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .secure(secure));
  cacx_aux_config i_dut (.sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .secure(secure), .rdata(rdata), .resp_valid(resp_valid),
    .resp(resp), .way_capacity_straps(straps), .assoc_strap(assoc),
    .cache_enable(o[18]), .early_resp_en(o[17]), .inst_prefetch_en(o[16]),
    .data_prefetch_en(o[15]), .int_access_ok(gate[0]), .lockdown_write_ok(gate[1]),
    .repl_round_robin(o[14]), .write_allocate_hint(o[13:12]), .shared_override(o[11]),
    .parity_en(o[10]), .event_bus_en(o[9]), .way_size(o[8:6]), .assoc_16way(o[5]),
    .shared_inval_en(o[4]), .exclusive_en(o[3]), .sb_device_limit(o[2]),
    .hipri_dev_reads(o[1]), .zero_line_en(o[0]));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////
  function automatic logic [17:0] exp_outs(input logic [31:0] v);
    logic [1:0] walloc;
    logic [2:0] ws;
    walloc = (v[24:23] == 2'h3) ? 2'h0 : v[24:23];
    ws = (v[19:17] == 3'h0) ? 3'h1 : ((v[19:17] == 3'h7) ? 3'h6 : v[19:17]);
    return {v[30], v[29], v[28], v[25], walloc, v[22], v[21], v[20], ws, v[16],
      v[13] & !v[22], v[12], v[11], v[10], v[0]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (fail_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic wr_chk(input logic [11:0] a, input logic [31:0] v, input logic sc,
    input logic [1:0] code);
    logic [1:0] g;
    i_mst.access(1'b1, a, v, sc, q, g);
    chk(q, {29'h0, 1'b1, code}, "write response");
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic sc, input logic [31:0] e);
    logic [1:0] g;
    logic hit;
    hit = (a == cacx_pkg::INT_MASK_OFS) || (a == cacx_pkg::INT_CLEAR_OFS);
    i_mst.access(1'b0, a, 32'h0, sc, q, g);
    chk(q, e, "read data");
    chk({30'h0, g}, {30'h0, sc | aux[26], hit & (sc | aux[27])}, "gates");
    chk({13'h0, o}, {13'h0, en, exp_outs(aux)}, "field outputs");
  endtask

  initial begin
    #(100 * 5000);
    fail_count++;
    tally_and_finish();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    fail_count = 0;
    num_checks = 0;
    en = 1'b0;
    void'($urandom(43900));
    straps = 3'($urandom);
    assoc = 1'($urandom);
    rst = 1'b1;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    aux = 32'h02000000 | {12'h0, straps, assoc, 16'h0};
    rd_chk(cacx_pkg::AUX_OFS, 1'b0, aux);
    for (int i = 0; i < 30; i++) begin
      d = (i == 0) ? 32'hFFFFFFFF : ((i == 1) ? 32'h00000000 : $urandom);
      s = (i < 2) ? 1'b1 : 1'($urandom);
      wr_chk(cacx_pkg::AUX_OFS, d, s, s ? cacx_pkg::RESP_OKAY : cacx_pkg::RESP_DECERR);
      if (s) begin
        aux = d & cacx_pkg::AUX_WMASK;
      end
      rd_chk(cacx_pkg::AUX_OFS, 1'($urandom), aux);
      rd_chk((i % 2) ? cacx_pkg::INT_MASK_OFS : cacx_pkg::INT_CLEAR_OFS, 1'($urandom),
        32'h0);
    end
    wr_chk(12'h3FC, 32'h1, 1'b1, cacx_pkg::RESP_DECERR);
    rd_chk(12'h3FC, 1'b1, 32'h0);
    wr_chk(cacx_pkg::CTRL_OFS, 32'h1, 1'b0, cacx_pkg::RESP_DECERR);
    rd_chk(cacx_pkg::CTRL_OFS, 1'b0, 32'h0);
    wr_chk(cacx_pkg::CTRL_OFS, 32'h1, 1'b1, cacx_pkg::RESP_OKAY);
    en = 1'b1;
    rd_chk(cacx_pkg::CTRL_OFS, 1'b0, 32'h1);
    wr_chk(cacx_pkg::AUX_OFS, ~aux, 1'b1, cacx_pkg::RESP_SLVERR);
    wr_chk(cacx_pkg::AUX_OFS, ~aux, 1'b0, cacx_pkg::RESP_DECERR);
    rd_chk(cacx_pkg::AUX_OFS, 1'b1, aux);
    wr_chk(cacx_pkg::CTRL_OFS, 32'h0, 1'b1, cacx_pkg::RESP_OKAY);
    en = 1'b0;
    wr_chk(cacx_pkg::AUX_OFS, ~aux, 1'b1, cacx_pkg::RESP_OKAY);
    aux = ~aux & cacx_pkg::AUX_WMASK;
    rd_chk(cacx_pkg::AUX_OFS, 1'b0, aux);
    // Second reset with fresh straps: every option returns to its default
    @(posedge sys_clk);
    straps <= 3'($urandom);
    assoc <= 1'($urandom);
    rst <= 1'h1;
    repeat (4) @(posedge sys_clk);
    rst <= 1'h0;
    aux = 32'h02000000 | {12'h0, straps, assoc, 16'h0};
    en = 1'h0;
    rd_chk(cacx_pkg::AUX_OFS, 1'h1, aux);
    rd_chk(cacx_pkg::CTRL_OFS, 1'h1, 32'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
